// *** rtl/alaw_pcm_codec.sv ***
/*
 codec end: a-law encoder and decoder timed by the conversion clock, a transmit
 shifter on the transmit bit clock and a receive shifter on the receive bit clock.
 assumes the controller frames each word with a gate, sampled on rising bit-clock edges.
*/
`timescale 1ns/10ps
`default_nettype none
`include "alaw_pcm_defs.svh"
module alaw_pcm_codec
    import alaw_pcm_pkg::*;
#(
    parameter int SAMPLE_CYCLES = `PCM_SAMPLE_CYCLES
) (
    // conversion clock and reset
    input  wire logic   clock,
    input  wire logic   rst_n,
    // link
    alaw_pcm_link_if.codec link,
    // linear audio, two's complement samples
    input  wire logic signed [`PCM_LIN_BITS-1:0] analogInput,
    output logic signed [`PCM_LIN_BITS-1:0]      analogOutput,
    output logic                                 sampleStrobe
);
    logic [15:0]  sampleCnt_reg;      // sample period divider
    pcm_word_t    codedWord_reg;      // newest coded sample
    logic         codedToggle_reg;    // flips when a new word is ready
    logic         rxTog0_reg;         // word-ready flag, first synchroniser stage
    logic         rxTog1_reg;         // word-ready flag, second synchroniser stage
    logic         rxTog2_reg;         // delayed copy for rising-edge detect
    pcm_word_t    rxHold_reg;         // received word after crossing
    logic         txTog0_reg;         // new-sample toggle, first synchroniser stage
    logic         txTog1_reg;         // new-sample toggle, second synchroniser stage
    logic         txTogSeen_reg;      // delayed copy for change detect
    logic         txLoadPend_reg;     // new word arrived while a frame was running
    pcm_word_t    txShift_reg;        // transmit shifter
    logic [3:0]   txCount_reg;        // bits sent in frame
    pcm_word_t    rxShift_reg;        // receive shifter
    logic [2:0]   rxCount_reg;        // bits captured in frame
    pcm_word_t    rxWord_reg;         // complete received word, stable while flag high
    logic         rxToggle_reg;       // word-ready flag: last bit taken until gate low
    logic         outVal_reg;         // transmit line value
    logic         outEn_reg;          // transmit enable

    // how the three clock domains meet
    //
    // the conversion side owns the sample timer, the encoder and the decoder.
    // the transmit shifter runs on the transmit bit clock and the receive
    // shifter on the receive bit clock; neither has a reset of its own,
    // because the pins carry none. the control state on the link side therefore
    // settles from the gates alone: a gate-low bit-clock edge clears the
    // counters, the output enable and the word-ready flag.
    //
    // into the transmit domain only a toggle crosses, through two flops.
    // the coded word itself is held still for a whole sample period, so it
    // is safe to copy once the toggle has been seen on the far side. a change
    // seen while a frame is running is remembered and applied after the gate
    // drops, so a word is never rewritten in the middle of being shifted.
    //
    // out of the receive domain a level flag crosses, high from the last bit
    // of a word until the gate goes low. the conversion side takes the word
    // on the flag's rising edge; by then the word register has stood still for
    // at least two conversion clocks.
    // limitation: the flag must last two conversion clocks, so the conversion
    // clock has to run at least twice as fast as the receive bit clock.
    //
    // trade-off: a word that lands just after a frame starts waits for the
    // next frame, one sample late, rather than risk a torn word on the line.

    // a-law encode of a linear magnitude
    function automatic pcm_word_t encode(input logic signed [`PCM_LIN_BITS-1:0] s);
        lin_mag_t    m;
        pcm_fields_t f;
        int          seg;
        m   = s[`PCM_LIN_BITS-1] ? lin_mag_t'(-s) : lin_mag_t'(s);
        seg = 0;
        if (m[`PCM_LIN_BITS-1]) m = 13'h0fff;               // clip at full scale
        for (int i = 11; i >= 5; i--) begin
            if (seg == 0 && m[i]) seg = i - 4;
        end
        f.sign  = ~s[`PCM_LIN_BITS-1];                       // positive codes sign 1
        f.chord = 3'(seg);
        f.step  = (seg == 0) ? m[4:1] : 4'(m >> seg);        // step doubles per chord above chord 1
        return f;
    endfunction

    // a-law decode to mid-step linear value
    function automatic logic signed [`PCM_LIN_BITS-1:0] decode(input pcm_word_t w);
        pcm_fields_t f;
        lin_mag_t    m;
        f = w;
        if (f.chord == 3'h0) m = lin_mag_t'({f.step, 1'b1});  // two lowest chords equal
        else m = lin_mag_t'({1'b1, f.step, 1'b1} << (f.chord - 3'h1));
        return f.sign ? $signed(m) : -$signed(m);
    endfunction

    // sample timer, encoder, 8 kHz
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sampleCnt_reg   <= 16'h0000;
            codedWord_reg   <= 8'hd5;
            codedToggle_reg <= 1'b0;
            sampleStrobe    <= 1'b0;
        end else if (sampleCnt_reg == 16'(SAMPLE_CYCLES - 1)) begin
            sampleCnt_reg   <= 16'h0000;
            codedWord_reg   <= encode(analogInput);
            codedToggle_reg <= ~codedToggle_reg;
            sampleStrobe    <= 1'b1;
        end else begin
            sampleCnt_reg   <= sampleCnt_reg + 16'h0001;
            sampleStrobe    <= 1'b0;
        end
    end

    // receive word crossing into conversion domain, decode held a full sample
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rxTog0_reg   <= 1'b0;
            rxTog1_reg   <= 1'b0;
            rxTog2_reg   <= 1'b0;
            rxHold_reg   <= 8'hd5;
            analogOutput <= '0;
        end else begin
            rxTog0_reg <= rxToggle_reg;
            rxTog1_reg <= rxTog0_reg;
            rxTog2_reg <= rxTog1_reg;
            // word is stable long before the toggle settles
            if (rxTog1_reg && !rxTog2_reg) rxHold_reg <= rxWord_reg;
            if (sampleCnt_reg == 16'h0000) analogOutput <= decode(rxHold_reg);
        end
    end

    // transmit shifter on its own clock; no reset pin, so idle state comes from gate low
    always_ff @(posedge link.txBitClock) begin
        // new-sample toggle: two flops, then a third copy for change detect
        txTog0_reg    <= codedToggle_reg;
        txTog1_reg    <= txTog0_reg;
        txTogSeen_reg <= txTog1_reg;
        // remember a new word that arrives mid-frame; cleared by any gate-low edge
        txLoadPend_reg <= link.txFrameGate &&
                          (txLoadPend_reg || (txTog1_reg != txTogSeen_reg));
        if (link.txFrameGate) begin
            // inside the frame: one bit per clock, sign first
            txShift_reg <= {txShift_reg[6:0], 1'b0};         // sign first
            txCount_reg <= txCount_reg + 4'h1;
            outVal_reg  <= txShift_reg[7];
            outEn_reg   <= 1'b1;
        end else begin
            // between frames: let go of the line and take a fresh word if a new one is pending or just flagged
            outEn_reg   <= 1'b0;
            txCount_reg <= 4'h0;
            if (txLoadPend_reg || (txTog1_reg != txTogSeen_reg)) begin
                txShift_reg <= codedWord_reg ^ `PCM_EVEN_INVERT;
            end
        end
    end

    // receive shifter on its own clock, independent of transmit
    always_ff @(posedge link.rxBitClock) begin
        if (link.rxFrameGate) begin
            rxShift_reg <= {rxShift_reg[6:0], link.serialIn}; // sign first
            rxCount_reg <= rxCount_reg + 3'h1;
            if (rxCount_reg == 3'h7) begin
                // eighth bit: the word is whole, undo the line inversion
                rxWord_reg   <= {rxShift_reg[6:0], link.serialIn} ^ `PCM_EVEN_INVERT;
                rxToggle_reg <= 1'b1;
            end
        end else begin
            // between frames: restart the count and drop the word-ready flag
            rxCount_reg  <= 3'h0;
            rxToggle_reg <= 1'b0;
        end
    end

    assign link.dataOut   = outVal_reg;
    assign link.dataOutEn = outEn_reg;
endmodule // alaw_pcm_codec
`default_nettype wire

// *** rtl/alaw_pcm_ctrl.sv ***
/*
 controller end: divides its clock into both bit clocks, frames one word each way
 per request, returns the word taken from the codec.
 assumes requests arrive no faster than one frame time each.
*/
`timescale 1ns/10ps
`default_nettype none
`include "alaw_pcm_defs.svh"
module alaw_pcm_ctrl
    import alaw_pcm_pkg::*;
#(
    parameter int HALF_DIV = 5   // system cycles per bit-clock half
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // link
    alaw_pcm_link_if.ctrl link,
    // user side
    input  wire logic      frameStart,   // level, held until busy: run one tx and one rx frame
    input  wire pcm_word_t sendWord,     // word sent to codec
    output pcm_word_t      takenWord,    // word read from codec
    output logic           takenValid,   // pulse with takenWord
    output logic           busy          // frame in progress
);
    typedef enum {IDLE, RUN} ctrl_state_t;
    ctrl_state_t state_reg;
    logic [7:0]  divCnt_reg;     // bit clock divider
    logic        bitClk_reg;     // shared bit clock out
    logic [3:0]  bitCnt_reg;     // bits framed
    pcm_word_t   sendShift_reg;  // outgoing word
    pcm_word_t   takeShift_reg;  // incoming word
    logic        din0_reg, din1_reg; // data line synchroniser

    // controller state, gates change just after the falling edge
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= IDLE; divCnt_reg <= 8'h00; bitClk_reg <= 1'b0;
            bitCnt_reg <= 4'h0; sendShift_reg <= 8'h00; takeShift_reg <= 8'h00;
            takenWord <= 8'h00; takenValid <= 1'b0; busy <= 1'b0;
            din0_reg <= 1'b0; din1_reg <= 1'b0;
        end else begin
            din0_reg <= link.dataOut & link.dataOutEn;
            din1_reg <= din0_reg;
            takenValid <= 1'b0;
            divCnt_reg <= (divCnt_reg == 8'(HALF_DIV - 1)) ? 8'h00 : divCnt_reg + 8'h01;
            if (divCnt_reg == 8'(HALF_DIV - 1)) bitClk_reg <= ~bitClk_reg;
            case (state_reg)
                IDLE: begin
                    if (frameStart && divCnt_reg == 8'(HALF_DIV - 1) && bitClk_reg) begin
                        state_reg <= RUN; busy <= 1'b1; bitCnt_reg <= 4'h0;
                        sendShift_reg <= sendWord ^ `PCM_EVEN_INVERT;
                    end
                end
                RUN: begin
                    // falling edge: advance one bit; gate held exactly eight periods
                    if (divCnt_reg == 8'(HALF_DIV - 1) && bitClk_reg) begin
                        bitCnt_reg    <= bitCnt_reg + 4'h1;
                        sendShift_reg <= {sendShift_reg[6:0], 1'b0};
                        takeShift_reg <= {takeShift_reg[6:0], din1_reg};
                        if (bitCnt_reg == 4'h8) begin
                            state_reg <= IDLE; busy <= 1'b0; takenValid <= 1'b1;
                            // eight bits already shifted in; strip the line inversion
                            takenWord <= takeShift_reg ^ `PCM_EVEN_INVERT;
                        end
                    end
                end
                default: state_reg <= IDLE;
            endcase
        end
    end

    assign link.txBitClock  = bitClk_reg;
    assign link.rxBitClock  = bitClk_reg;  // codec tolerates any relation
    assign link.txFrameGate = busy && bitCnt_reg < 4'h8;
    assign link.rxFrameGate = busy && bitCnt_reg < 4'h8;
    assign link.serialIn    = sendShift_reg[7];
endmodule // alaw_pcm_ctrl
`default_nettype wire

// *** rtl/alaw_pcm_defs.svh ***
/*
 constants for the a-law pcm serial port: word layout, timing figures, sample rate.
 assumes it is included by its bare name from the package and the two end modules.
*/
// Behaviour
// - eight bits: sign, three chord, four step
// - sign bit goes first both directions
// - step size doubles for each chord; the codec gives chords 0 and 1 the same step size
// - one coded word per 8 kHz sample
// - conversion timed only by conversion clock
// - controller holds transmit gate eight clocks
// - one bit out per gated transmit clock
// - output floats while transmit gate low; the codec lets go at the first rising transmit clock after the gate falls
// - even bit positions inverted on transmit
// - controller holds receive gate eight clocks
// - one bit captured per gated receive clock
// - receive and transmit clocks fully asynchronous
// - transmit and receive sections fully independent
// - received word held at decoder whole sample
// - transmit bit clock at most 2.1 MHz
`ifndef ALAW_PCM_DEFS_SVH
`define ALAW_PCM_DEFS_SVH
`define PCM_WORD_BITS      8
`define PCM_SIGN_POS       7
`define PCM_CHORD_MSB      6
`define PCM_CHORD_LSB      4
`define PCM_STEP_MSB       3
`define PCM_STEP_LSB       0
`define PCM_EVEN_INVERT    8'h55
`define PCM_SAMPLE_HZ      8000
`define PCM_SYS_CLOCK_HZ   20000000
`define PCM_SAMPLE_CYCLES  (`PCM_SYS_CLOCK_HZ / `PCM_SAMPLE_HZ)
`define PCM_SAMPLE_RESET   12'h000
`define PCM_LIN_BITS       13
`endif

// *** rtl/alaw_pcm_link_if.sv ***
/*
 link between the codec serial port and the time-slot controller.
 assumes the testbench resolves the shared data line from dataOut and dataOutEn.
*/
`timescale 1ns/10ps
`default_nettype none
interface alaw_pcm_link_if;
    logic txBitClock;    // transmit bit clock, made by controller
    logic txFrameGate;   // transmit gate, high for eight bits
    logic dataOut;       // codec serial output value
    logic dataOutEn;     // codec output enable, high while driving
    logic rxBitClock;    // receive bit clock, made by controller
    logic rxFrameGate;   // receive gate, high for eight bits
    logic serialIn;      // codec serial input
    modport codec (input txBitClock, txFrameGate, rxBitClock, rxFrameGate, serialIn,
                   output dataOut, dataOutEn);
    modport ctrl (output txBitClock, txFrameGate, rxBitClock, rxFrameGate, serialIn,
                  input dataOut, dataOutEn);
endinterface
`default_nettype wire

// *** rtl/alaw_pcm_pkg.sv ***
/*
 types shared by both ends of the pcm serial link.
 assumes the constants header is on the include path.
*/
`include "alaw_pcm_defs.svh"
package alaw_pcm_pkg;
    typedef logic [`PCM_WORD_BITS-1:0] pcm_word_t;   // companded word
    typedef logic [`PCM_LIN_BITS-1:0]  lin_mag_t;    // linear magnitude
    typedef struct packed {
        logic       sign;
        logic [2:0] chord;
        logic [3:0] step;
    } pcm_fields_t;
endpackage

// *** verification/alaw_pcm_props.sv ***
/*
 concurrent checks on the pcm link between codec and controller.
 assumes the bench instantiates it beside the interface, on the controller clock.
*/
`timescale 1ns/10ps
`default_nettype none
module alaw_pcm_props (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // link signals
    input wire logic txBitClock,
    input wire logic txFrameGate,
    input wire logic dataOut,
    input wire logic dataOutEn,
    input wire logic rxBitClock,
    input wire logic rxFrameGate
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic       txPrev;   // bit clocks one cycle back
    logic       rxPrev;
    logic [3:0] txCnt;    // gated rising edges per frame
    logic [3:0] rxCnt;
    // edge detect: bit clocks come from the same clock, so a delayed copy suffices
    always_ff @(posedge clock) begin
        txPrev <= txBitClock;
        rxPrev <= rxBitClock;
    end
    // count transmit bits inside the gate
    always_ff @(posedge clock) begin
        if (!rst_n || !txFrameGate) txCnt <= 4'h0;
        else if (txBitClock && !txPrev) txCnt <= txCnt + 4'h1;
    end
    // count receive bits inside the gate
    always_ff @(posedge clock) begin
        if (!rst_n || !rxFrameGate) rxCnt <= 4'h0;
        else if (rxBitClock && !rxPrev) rxCnt <= rxCnt + 4'h1;
    end
    chk_tx_gate_len: assert property ($fell(txFrameGate) |-> txCnt == 4'h8)
        else $error("transmit gate not eight bits long");
    chk_rx_gate_len: assert property ($fell(rxFrameGate) |-> rxCnt == 4'h8)
        else $error("receive gate not eight bits long");
    chk_tx_gate_sync: assert property ($changed(txFrameGate) |-> !txBitClock)
        else $error("transmit gate moved while bit clock high");
    chk_rx_gate_sync: assert property ($changed(rxFrameGate) |-> !rxBitClock)
        else $error("receive gate moved while bit clock high");
    chk_out_float: assert property ($rose(txBitClock) && !txFrameGate |-> !dataOutEn)
        else $error("output driven outside transmit gate");
    chk_enable_drop: assert property ($fell(txFrameGate) |-> ##[1:12] !dataOutEn)
        else $error("output still driven after frame");
    chk_bit_hold: assert property (
        !$rose(txBitClock) && $past(dataOutEn) && dataOutEn |-> $stable(dataOut))
        else $error("output bit changed between bit clocks");
    chk_clock_rate: assert property ($rose(txBitClock) |=> txBitClock [*4])
        else $error("transmit bit clock high phase too short");
    cov_tx_frame: cover property ($fell(txFrameGate));
    cov_rx_frame: cover property ($fell(rxFrameGate));
    cov_drive: cover property ($rose(dataOutEn));
endmodule // alaw_pcm_props
`default_nettype wire

// *** verification/tb_top.sv ***
/*
 self-checking bench: controller and codec joined by the link interface.
 assumes one 20 mhz clock drives both ends; the controller makes the bit clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import alaw_pcm_pkg::*;
    logic                clock = 1'b0;       // shared system clock
    logic                rst_n = 1'b0;       // synchronous reset
    logic                frameStart = 1'b0;  // frame request
    pcm_word_t           sendWord = 8'h00;   // word sent to codec
    pcm_word_t           takenWord;          // word read back
    pcm_word_t           lineWord;           // bits seen on the wire
    logic                takenValid;
    logic                busy;
    logic                lineLevel;          // resolved shared data line
    logic signed [12:0]  analogInput = 13'h0000;
    logic signed [12:0]  analogOutput;
    int                  fails = 0;
    int                  samplesChecked = 0;
    int                  cycles = 0;
    int                  lineBits = 0;
    int                  vals[5] = '{1, 32, 200, 4095, -1000};
    alaw_pcm_link_if link();
    alaw_pcm_codec #(.SAMPLE_CYCLES(50)) alaw_pcm_codec_i (.clock(clock), .rst_n(rst_n),
        .link(link), .analogInput(analogInput), .analogOutput(analogOutput),
        .sampleStrobe());
    alaw_pcm_ctrl alaw_pcm_ctrl_i (.clock(clock), .rst_n(rst_n), .link(link),
        .frameStart(frameStart), .sendWord(sendWord), .takenWord(takenWord),
        .takenValid(takenValid), .busy(busy));
    alaw_pcm_props alaw_pcm_props_i (.clock(clock), .rst_n(rst_n),
        .txBitClock(link.txBitClock), .txFrameGate(link.txFrameGate),
        .dataOut(link.dataOut), .dataOutEn(link.dataOutEn),
        .rxBitClock(link.rxBitClock), .rxFrameGate(link.rxFrameGate));
    // the line floats when the codec lets go
    assign lineLevel = link.dataOutEn ? link.dataOut : 1'bz;
    initial forever #25 clock = ~clock;
    // wire watcher: sample mid-bit, on the falling bit clock edge
    always @(negedge link.txBitClock) begin
        if (link.dataOutEn) begin
            lineWord = {lineWord[6:0], lineLevel};
            lineBits++;
        end
    end
    // hang guard, well beyond five test passes
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    // segmented encode: chord from the magnitude's top bit, four step bits below it
    function automatic pcm_word_t enc(input int x);
        int m;
        int c;
        m = (x < 0) ? -x : x;
        c = 0;
        while (c < 7 && m >= (32 << c)) c++;
        return {x >= 0, 3'(c), 4'(m >> ((c == 0) ? 1 : c))};
    endfunction
    // inverse mapping at mid-step
    function automatic logic [12:0] dec(input pcm_word_t w);
        int m;
        m = (w[6:4] == 3'h0) ? w[3:0] * 2 + 1 : (w[3:0] * 2 + 33) << (w[6:4] - 1);
        return w[7] ? 13'(m) : 13'(-m);
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one request; waits for the returned word under a bound
    task automatic frame(input pcm_word_t w);
        int n;
        n = 0;
        while (busy && n < 400) begin
            @(negedge clock);
            n++;
        end
        lineBits = 0;
        sendWord = w;
        frameStart = 1'b1;
        // the controller only starts on a bit-clock falling point
        while (!busy && n < 400) begin
            @(negedge clock);
            n++;
        end
        frameStart = 1'b0;
        while (!takenValid && n < 800) begin
            @(negedge clock);
            n++;
        end
        if (n >= 800) fails++;
    endtask
    task report_and_stop;
        if (fails == 0 && samplesChecked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        for (int i = 0; i < 5; i++) begin
            analogInput = 13'(vals[i]);
            repeat (150) @(negedge clock);
            // first frame already carries the new sample, second carries it again and is checked
            frame(8'h00);
            frame(8'h85 + 8'(i * 8'h27));
            check(16'(takenWord), 16'(enc(vals[i])));
            check(16'(lineWord), 16'(enc(vals[i]) ^ 8'h55));
            check(16'(lineBits), 16'h0008);
            repeat (150) @(negedge clock);
            check(16'(unsigned'(analogOutput)), 16'(dec(sendWord)));
        end
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
